// File: rtl/tpc_bank.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Page bit picks page 0 or 1
// - Low-pulse preset readable, counter eight-bit prescaled
// - Low-pulse counter reloads preset after interrupt
// - Low phase lasts ratio times preset plus one
// - Mask holds eight enables, one enables
// - Wake bits active low, lower nibble only
// - Wake-up enabled after reset
// - External interrupt 0 edge select
// - Global enable flag read-only, instruction driven
// - Time counter source instruction clock or pin
// - Pin edge select for time counter
// - Time counter prescale 1:1 or 1:2..1:256
// - Watchdog enable bit, upper nibble unused
// - Watchdog prescale 1:1..1:128 on sub clock
// - Counter 2 source sub or main
// - Counter 2 ratio 1:2..1:256
// - Counter 1 source sub or main
// - Counter 1 ratio 1:2..1:256
// - Low-pulse timer source and ratio
// - High-pulse timer source and ratio
// - High preset sets high phase, alternating
// - Counters 1 and 2 reload preset
module tpc_bank
  import tpc_pkg::*;
(
  input  logic       mclk_i,
  input  logic       rst_i,
  input  logic [3:0] addr_i,
  input  logic [7:0] wdata_i,
  input  logic       wr_i,
  input  logic       rd_i,
  input  logic       page_sel_i,
  input  logic       sub_osc_clock_i,
  input  logic       main_osc_clock_i,
  input  logic       tcc_pin_i,
  input  logic       ext_irq_zero_pin_i,
  input  logic       instr_tick_i,
  input  logic       disable_irq_instr_i,
  input  logic       enable_irq_instr_i,
  input  logic       return_irq_instr_i,
  input  logic       irq_entry_i,
  output logic [7:0] rdata_o,
  output logic [3:0] wake_en_o,
  output logic       ir_sink_strength_o,
  output logic       watchdog_en_o,
  output logic       watchdog_tick_o,
  output logic       time_counter_tick_o,
  output logic       ext0_irq_o,
  output logic       cnt1_irq_o,
  output logic       cnt2_irq_o,
  output logic       hipw_irq_o,
  output logic       lopw_irq_o,
  output logic       pwm_o
);

  logic [7:0]  wake_ff,   nxt_wake;
  logic [7:0]  tctl_ff,   nxt_tctl;
  logic [3:0]  wdog_ff,   nxt_wdog;
  logic [7:0]  cntsrc_ff, nxt_cntsrc;
  logic [7:0]  pulsrc_ff, nxt_pulsrc;
  logic [7:0]  mask_ff,   nxt_mask;
  logic [7:0]  nxt_rdata;
  logic        gie_ff,    nxt_gie;
  logic [7:0]  preset_ff [4];
  logic [7:0]  nxt_preset [4];
  logic [3:0]  rise_w;
  logic [3:0]  fall_w;
  logic [3:0]  term_w;
  logic [3:0]  ch_src;
  logic [2:0]  ch_code [4];
  logic [3:0]  ch_run;
  tpc_phase_t  phase_ff,  nxt_phase;

  // Pin sampling: three stages, a change counts when stages two and three agree
  generate
    for (genvar p = 0; p < 4; p++)
    begin : pin
      logic [2:0] sync_ff;
      logic       lvl_ff;
      logic       nxt_lvl;
      logic [2:0] nxt_sync;
      always_comb
      begin
        nxt_sync = {sync_ff[1:0], 1'b0};
        case (p)
          PIN_SUB:  nxt_sync[0] = sub_osc_clock_i;
          PIN_MAIN: nxt_sync[0] = main_osc_clock_i;
          PIN_TCC:  nxt_sync[0] = tcc_pin_i;
          default:  nxt_sync[0] = ext_irq_zero_pin_i;
        endcase
        nxt_lvl = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
      end
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          sync_ff <= 3'h0;
          lvl_ff  <= 1'b0;
        end
        else
        begin
          sync_ff <= nxt_sync;
          lvl_ff  <= nxt_lvl;
        end
      end
      assign rise_w[p] = nxt_lvl & ~lvl_ff;
      assign fall_w[p] = ~nxt_lvl & lvl_ff;
    end
  endgenerate

  // Per-channel source bit and ratio code
  assign ch_src[CH_C1]  = cntsrc_ff[SRC_LO_BIT];
  assign ch_code[CH_C1] = cntsrc_ff[SRC_LO_BIT-1:0];
  assign ch_src[CH_C2]  = cntsrc_ff[SRC_UP_BIT];
  assign ch_code[CH_C2] = cntsrc_ff[SRC_UP_BIT-1:SRC_LO_BIT+1];
  assign ch_src[CH_HI]  = pulsrc_ff[SRC_LO_BIT];
  assign ch_code[CH_HI] = pulsrc_ff[SRC_LO_BIT-1:0];
  assign ch_src[CH_LO]  = pulsrc_ff[SRC_UP_BIT];
  assign ch_code[CH_LO] = pulsrc_ff[SRC_UP_BIT-1:SRC_LO_BIT+1];
  // Counters 1, 2 run freely; pulse timers run only in their own phase
  assign ch_run = {phase_ff == PH_LOW, phase_ff == PH_HIGH, 2'b11};

  // Prescaled down-counters with auto-reload
  generate
    for (genvar c = 0; c < 4; c++)
    begin : ch
      logic [7:0] pre_ff, nxt_pre;
      logic [7:0] cnt_ff, nxt_cnt;
      logic [7:0] lim;
      logic       edge_w;
      logic       tick_w;
      always_comb
      begin
        lim    = 8'hFF >> (3'h7 - ch_code[c]);
        edge_w = ch_src[c] ? rise_w[PIN_MAIN] : rise_w[PIN_SUB];
        // At or past the limit, so a ratio lowered mid-count never wraps through 255
        tick_w = ch_run[c] & edge_w & (pre_ff >= lim);
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        if (!ch_run[c])
        begin
          nxt_pre = 8'h00;
          nxt_cnt = preset_ff[c];
        end
        else if (edge_w)
        begin
          nxt_pre = (pre_ff >= lim) ? 8'h00 : pre_ff + 8'h01;
        end
        if (tick_w)
          nxt_cnt = (cnt_ff == 8'h00) ? preset_ff[c] : cnt_ff - 8'h01;
      end
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          pre_ff <= 8'h00;
          cnt_ff <= RST_CNT;
        end
        else
        begin
          pre_ff <= nxt_pre;
          cnt_ff <= nxt_cnt;
        end
      end
      assign term_w[c] = tick_w & (cnt_ff == 8'h00);
    end
  endgenerate

  // High and low phases alternate on each pulse timer's terminal count
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_HIGH: if (term_w[CH_HI]) nxt_phase = PH_LOW;
      PH_LOW:  if (term_w[CH_LO]) nxt_phase = PH_HIGH;
      default: nxt_phase = PH_HIGH;
    endcase
  end

  // Time counter and watchdog prescalers
  logic [7:0] tpre_ff, nxt_tpre;
  logic [6:0] wpre_ff, nxt_wpre;
  logic [7:0] tlim;
  logic [6:0] wlim;
  logic       tsrc_edge;
  logic       nxt_ttick;
  logic       nxt_wtick;
  always_comb
  begin
    tlim = tctl_ff[TCTL_PSEN] ? (8'hFF >> (3'h7 - tctl_ff[2:0])) : 8'h00;
    tsrc_edge = tctl_ff[TCTL_SRC]
              ? (tctl_ff[TCTL_PIN_EDGE] ? fall_w[PIN_TCC] : rise_w[PIN_TCC])
              : instr_tick_i;
    nxt_ttick = tsrc_edge & (tpre_ff >= tlim);
    nxt_tpre  = tsrc_edge ? ((tpre_ff >= tlim) ? 8'h00 : tpre_ff + 8'h01) : tpre_ff;
    wlim = 7'h7F >> (3'h7 - wdog_ff[2:0]);
    nxt_wtick = wdog_ff[WDOG_EN] & rise_w[PIN_SUB] & (wpre_ff >= wlim);
    nxt_wpre  = wpre_ff;
    if (!wdog_ff[WDOG_EN])
      nxt_wpre = 7'h00;
    else if (rise_w[PIN_SUB])
      nxt_wpre = (wpre_ff >= wlim) ? 7'h00 : wpre_ff + 7'h01;
  end

  // Global interrupt enable: enabling instructions win over disabling events
  always_comb
  begin
    nxt_gie = gie_ff;
    if (enable_irq_instr_i | return_irq_instr_i)
      nxt_gie = 1'b1;
    else if (disable_irq_instr_i | irq_entry_i)
      nxt_gie = 1'b0;
  end

  // Register writes and registered read data, decoded by page
  always_comb
  begin
    nxt_wake   = wake_ff;
    nxt_tctl   = tctl_ff;
    nxt_wdog   = wdog_ff;
    nxt_cntsrc = cntsrc_ff;
    nxt_pulsrc = pulsrc_ff;
    nxt_mask   = mask_ff;
    nxt_rdata  = 8'h00;
    for (int k = 0; k < 4; k++)
      nxt_preset[k] = preset_ff[k];
    if (wr_i)
    begin
      if (!page_sel_i)
      begin
        unique case (addr_i)
          OFS_C1PRE: nxt_preset[CH_C1] = wdata_i;
          OFS_C2PRE: nxt_preset[CH_C2] = wdata_i;
          OFS_HIPRE: nxt_preset[CH_HI] = wdata_i;
          OFS_LOPRE: nxt_preset[CH_LO] = wdata_i;
          OFS_MASK:  nxt_mask = wdata_i;
          default:   nxt_mask = mask_ff;
        endcase
      end
      else
      begin
        unique case (addr_i)
          OFS_WAKE:   nxt_wake = {wdata_i[7], 3'h0, wdata_i[3:0]};
          OFS_TCTL:   nxt_tctl = wdata_i;
          OFS_WDOG:   nxt_wdog = wdata_i[3:0];
          OFS_CNTSRC: nxt_cntsrc = wdata_i;
          OFS_PULSRC: nxt_pulsrc = wdata_i;
          default:    nxt_wake = wake_ff;
        endcase
      end
    end
    if (rd_i)
    begin
      if (!page_sel_i)
      begin
        unique case (addr_i)
          OFS_C1PRE: nxt_rdata = preset_ff[CH_C1];
          OFS_C2PRE: nxt_rdata = preset_ff[CH_C2];
          OFS_HIPRE: nxt_rdata = preset_ff[CH_HI];
          OFS_LOPRE: nxt_rdata = preset_ff[CH_LO];
          OFS_MASK:  nxt_rdata = mask_ff;
          default:   nxt_rdata = 8'h00;
        endcase
      end
      else
      begin
        unique case (addr_i)
          OFS_WAKE:   nxt_rdata = wake_ff;
          OFS_TCTL:   nxt_rdata = {tctl_ff[7], gie_ff, tctl_ff[5:0]};
          OFS_WDOG:   nxt_rdata = {4'h0, wdog_ff};
          OFS_CNTSRC: nxt_rdata = cntsrc_ff;
          OFS_PULSRC: nxt_rdata = pulsrc_ff;
          default:    nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  // Interrupt requests gated by mask and global enable
  logic ext0_edge;
  logic irq_ok;
  assign ext0_edge = tctl_ff[TCTL_EXT0_EDGE] ? fall_w[PIN_EXT0] : rise_w[PIN_EXT0];
  assign irq_ok    = gie_ff;

  // State registers and flopped outputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      wake_ff             <= RST_WAKE;
      tctl_ff             <= RST_TCTL;
      wdog_ff             <= RST_WDOG;
      cntsrc_ff           <= RST_SRC;
      pulsrc_ff           <= RST_SRC;
      mask_ff             <= RST_MASK;
      gie_ff              <= 1'b0;
      phase_ff            <= PH_HIGH;
      tpre_ff             <= 8'h00;
      wpre_ff             <= 7'h00;
      for (int k = 0; k < 4; k++)
        preset_ff[k] <= RST_PRE;
      rdata_o             <= 8'h00;
      wake_en_o           <= 4'hF;
      ir_sink_strength_o  <= 1'b0;
      watchdog_en_o       <= 1'b0;
      watchdog_tick_o     <= 1'b0;
      time_counter_tick_o <= 1'b0;
      ext0_irq_o          <= 1'b0;
      cnt1_irq_o          <= 1'b0;
      cnt2_irq_o          <= 1'b0;
      hipw_irq_o          <= 1'b0;
      lopw_irq_o          <= 1'b0;
      pwm_o               <= 1'b1;
    end
    else
    begin
      wake_ff             <= nxt_wake;
      tctl_ff             <= nxt_tctl;
      wdog_ff             <= nxt_wdog;
      cntsrc_ff           <= nxt_cntsrc;
      pulsrc_ff           <= nxt_pulsrc;
      mask_ff             <= nxt_mask;
      gie_ff              <= nxt_gie;
      phase_ff            <= nxt_phase;
      tpre_ff             <= nxt_tpre;
      wpre_ff             <= nxt_wpre;
      for (int k = 0; k < 4; k++)
        preset_ff[k] <= nxt_preset[k];
      rdata_o             <= nxt_rdata;
      wake_en_o           <= ~nxt_wake[3:0];
      ir_sink_strength_o  <= nxt_wake[WAKE_IR_SINK];
      watchdog_en_o       <= nxt_wdog[WDOG_EN];
      watchdog_tick_o     <= nxt_wtick;
      time_counter_tick_o <= nxt_ttick;
      ext0_irq_o          <= ext0_edge & mask_ff[IRQ_EXT0] & irq_ok;
      cnt1_irq_o          <= term_w[CH_C1] & mask_ff[IRQ_CNT1] & irq_ok;
      cnt2_irq_o          <= term_w[CH_C2] & mask_ff[IRQ_CNT2] & irq_ok;
      hipw_irq_o          <= term_w[CH_HI] & mask_ff[IRQ_HIPW] & irq_ok;
      lopw_irq_o          <= term_w[CH_LO] & mask_ff[IRQ_LOPW] & irq_ok;
      pwm_o               <= (nxt_phase == PH_HIGH);
    end
  end

  // Checks
  a_page_mask_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && !page_sel_i && addr_i == OFS_MASK |=> rdata_o == $past(mask_ff))
    else $error("mask read returned wrong data");
  a_wdog_upper_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_i && page_sel_i && addr_i == OFS_WDOG |=> rdata_o == {4'h0, $past(wdog_ff)})
    else $error("watchdog upper bits not zero");
  a_gie_cleared: assert property (@(posedge mclk_i) disable iff (rst_i)
    (disable_irq_instr_i || irq_entry_i) && !enable_irq_instr_i && !return_irq_instr_i |=> !gie_ff)
    else $error("global enable not cleared");
  a_wake_inverted: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && page_sel_i && addr_i == OFS_WAKE |=> wake_en_o == ~$past(wdata_i[3:0]))
    else $error("wake enable not inverse of written bits");
  a_low_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
    term_w[CH_LO] |=> phase_ff == PH_HIGH ##1 ch[CH_LO].cnt_ff == preset_ff[CH_LO])
    else $error("low-pulse counter not reloaded");
  a_cnt1_reload: assert property (@(posedge mclk_i) disable iff (rst_i)
    term_w[CH_C1] |=> ch[CH_C1].cnt_ff == $past(preset_ff[CH_C1]))
    else $error("counter 1 not reloaded");
  a_irq_gated: assert property (@(posedge mclk_i) disable iff (rst_i)
    cnt1_irq_o |-> $past(mask_ff[IRQ_CNT1]) && $past(gie_ff) && $past(term_w[CH_C1]))
    else $error("counter 1 irq without enables");
  a_ext0_rising: assert property (@(posedge mclk_i) disable iff (rst_i)
    rise_w[PIN_EXT0] && !tctl_ff[TCTL_EXT0_EDGE] && mask_ff[IRQ_EXT0] && gie_ff |=> ext0_irq_o)
    else $error("ext0 rising edge missed");
  a_tcc_direct: assert property (@(posedge mclk_i) disable iff (rst_i)
    instr_tick_i && !tctl_ff[TCTL_SRC] && !tctl_ff[TCTL_PSEN] |=> time_counter_tick_o)
    else $error("1:1 time counter tick missing");
  a_wdog_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    !wdog_ff[WDOG_EN] |=> !watchdog_tick_o)
    else $error("watchdog ticked while disabled");

endmodule : tpc_bank

// File: common/tpc_pkg.sv
package tpc_pkg;
  // Register offsets, page 0 (page select bit low)
  localparam logic [3:0] OFS_C1PRE  = 4'hB;
  localparam logic [3:0] OFS_C2PRE  = 4'hC;
  localparam logic [3:0] OFS_HIPRE  = 4'hD;
  localparam logic [3:0] OFS_LOPRE  = 4'hE;
  localparam logic [3:0] OFS_MASK   = 4'hF;
  // Register offsets, page 1 (page select bit high)
  localparam logic [3:0] OFS_WAKE   = 4'h6;
  localparam logic [3:0] OFS_TCTL   = 4'h7;
  localparam logic [3:0] OFS_WDOG   = 4'h8;
  localparam logic [3:0] OFS_CNTSRC = 4'h9;
  localparam logic [3:0] OFS_PULSRC = 4'hA;
  // Time counter control fields
  localparam int TCTL_EXT0_EDGE = 7;
  localparam int TCTL_GIE       = 6;
  localparam int TCTL_SRC       = 5;
  localparam int TCTL_PIN_EDGE  = 4;
  localparam int TCTL_PSEN      = 3;
  // Watchdog control fields
  localparam int WDOG_EN        = 3;
  // Wake control fields
  localparam int WAKE_IR_SINK   = 7;
  // Source/ratio register fields: upper nibble and lower nibble
  localparam int SRC_UP_BIT     = 7;
  localparam int SRC_LO_BIT     = 3;
  // Interrupt mask bit positions
  localparam int IRQ_TCC        = 0;
  localparam int IRQ_EXT0       = 1;
  localparam int IRQ_EXT1       = 2;
  localparam int IRQ_CNT1       = 3;
  localparam int IRQ_CNT2       = 4;
  localparam int IRQ_HIPW       = 5;
  localparam int IRQ_LOPW       = 6;
  localparam int IRQ_CAP        = 7;
  // Values after reset
  localparam logic [7:0] RST_WAKE   = 8'h00;
  localparam logic [7:0] RST_TCTL   = 8'hBF;
  localparam logic [3:0] RST_WDOG   = 4'h0;
  localparam logic [7:0] RST_SRC    = 8'h00;
  localparam logic [7:0] RST_PRE    = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_CNT    = 8'h00;
  // Down-counter channel indices
  localparam int CH_C1 = 0;
  localparam int CH_C2 = 1;
  localparam int CH_HI = 2;
  localparam int CH_LO = 3;
  // Sampled pin indices
  localparam int PIN_SUB  = 0;
  localparam int PIN_MAIN = 1;
  localparam int PIN_TCC  = 2;
  localparam int PIN_EXT0 = 3;
  // Output waveform phase
  typedef enum logic [1:0] {PH_HIGH = 2'b01, PH_LOW = 2'b10} tpc_phase_t;
endpackage : tpc_pkg

// File: test/tpc_bank_tb_top.sv
`timescale 1ns/1ps
module tpc_bank_tb_top;
  import tpc_pkg::*;
  logic       mclk_i              = 1'b0;
  logic       rst_i               = 1'b1;
  logic [3:0] addr_i              = 4'h0;
  logic [7:0] wdata_i             = 8'h00;
  logic       wr_i                = 1'b0;
  logic       rd_i                = 1'b0;
  logic       page_sel_i          = 1'b0;
  logic       sub_osc_clock_i     = 1'b0;
  logic       main_osc_clock_i    = 1'b0;
  logic       tcc_pin_i           = 1'b0;
  logic       ext_irq_zero_pin_i  = 1'b0;
  logic       instr_tick_i        = 1'b0;
  logic       disable_irq_instr_i = 1'b0;
  logic       enable_irq_instr_i  = 1'b0;
  logic       return_irq_instr_i  = 1'b0;
  logic       irq_entry_i         = 1'b0;
  logic [7:0] rdata_o;
  logic [3:0] wake_en_o;
  logic       watchdog_en_o;
  logic [7:0] ev;
  logic [7:0] rv;
  logic       sink_w;
  logic       pwm_w;
  int         errors              = 0;
  int         n_tests             = 0;
  int         cyc                 = 0;
  int         c;
  int         l0;
  int         l1;

  tpc_bank tpc_bank_i (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .page_sel_i(page_sel_i), .sub_osc_clock_i(sub_osc_clock_i),
    .main_osc_clock_i(main_osc_clock_i), .tcc_pin_i(tcc_pin_i), .ext_irq_zero_pin_i(ext_irq_zero_pin_i),
    .instr_tick_i(instr_tick_i), .disable_irq_instr_i(disable_irq_instr_i),
    .enable_irq_instr_i(enable_irq_instr_i), .return_irq_instr_i(return_irq_instr_i),
    .irq_entry_i(irq_entry_i), .rdata_o(rdata_o), .wake_en_o(wake_en_o), .ir_sink_strength_o(sink_w),
    .watchdog_en_o(watchdog_en_o), .watchdog_tick_o(ev[5]), .time_counter_tick_o(ev[6]),
    .ext0_irq_o(ev[0]), .cnt1_irq_o(ev[1]), .cnt2_irq_o(ev[2]), .hipw_irq_o(ev[3]), .lopw_irq_o(ev[4]),
    .pwm_o(pwm_w));
  // Low phase start is watched as a rising event
  assign ev[7] = ~pwm_w;

  always #2.5 mclk_i = ~mclk_i;

  // Oscillators: sub period 6 cycles, main 8, pin 10, instruction tick every 2
  always @(posedge mclk_i)
  begin
    cyc              <= cyc + 1;
    sub_osc_clock_i  <= (cyc % 6) < 3;
    main_osc_clock_i <= (cyc % 8) < 4;
    tcc_pin_i        <= (cyc % 10) < 5;
    instr_tick_i     <= cyc[0];
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Compare a byte value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Compare a counted interval or number of events
  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  task automatic wr(input logic pg, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    page_sel_i <= pg;
    addr_i     <= a;
    wdata_i    <= d;
    wr_i       <= 1'b1;
    @(posedge mclk_i);
    wr_i       <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic pg, input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    page_sel_i <= pg;
    addr_i     <= a;
    rd_i       <= 1'b1;
    @(posedge mclk_i);
    rd_i       <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : chk_rd

  // One-cycle CPU pulse: 0 enable, 1 disable, 2 return, 3 entry
  task automatic cpu(input int k);
    @(posedge mclk_i);
    {irq_entry_i, return_irq_instr_i, disable_irq_instr_i, enable_irq_instr_i} <= 4'(1 << k);
    @(posedge mclk_i);
    {irq_entry_i, return_irq_instr_i, disable_irq_instr_i, enable_irq_instr_i} <= 4'h0;
  endtask : cpu

  // Count rising events on one watched signal over a window
  task automatic cnt(input int idx, input int n, output int k);
    logic p;
    k = 0;
    p = ev[idx];
    repeat (n)
    begin
      @(posedge mclk_i);
      #1;
      if (ev[idx] && !p)
        k++;
      p = ev[idx];
    end
  endtask : cnt

  // Interval between the second and third event, bounded wait
  task automatic gap(input int idx, input int exp);
    int  n;
    int  t0;
    int  k;
    logic p;
    n = 0;
    t0 = 0;
    k = 0;
    p = ev[idx];
    while (k < 3 && n < 4000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
      if (ev[idx] && !p)
      begin
        k++;
        if (k == 2)
          t0 = n;
        if (k == 3)
          chk_n(n - t0, exp);
      end
      p = ev[idx];
    end
    if (k < 3)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, k, 3);
      finish_test();
    end
  endtask : gap

  // Cycles from a pin rise to the next time counter tick
  task automatic lag(output int n);
    int w;
    n = 0;
    w = 0;
    @(posedge mclk_i);
    #1;
    while (tcc_pin_i !== 1'b0 && w < 40)
    begin
      @(posedge mclk_i);
      #1;
      w++;
    end
    while (tcc_pin_i !== 1'b1 && w < 40)
    begin
      @(posedge mclk_i);
      #1;
      w++;
    end
    while (ev[6] !== 1'b1 && n < 40)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (w >= 40 || n >= 40)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 40);
      finish_test();
    end
  endtask : lag

  // Move the interrupt pin and count requests that follow
  task automatic ext(input logic v, input int exp);
    int k;
    @(posedge mclk_i);
    ext_irq_zero_pin_i <= v;
    cnt(0, 20, k);
    chk_n(k, exp);
  endtask : ext

  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk_rd(1'b1, OFS_WAKE, 8'h00);
    chk({4'h0, wake_en_o}, 8'h0F);
    chk_rd(1'b1, OFS_TCTL, 8'hBF);
    chk_rd(1'b1, OFS_WDOG, 8'h00);
    chk_rd(1'b0, OFS_MASK, 8'h00);
    $display("reset test done");
    wr(1'b0, OFS_LOPRE, 8'hA5);
    chk_rd(1'b0, OFS_LOPRE, 8'hA5);
    chk_rd(1'b1, OFS_LOPRE, 8'h00);
    wr(1'b1, OFS_LOPRE, 8'h3C);
    chk_rd(1'b0, OFS_LOPRE, 8'hA5);
    wr(1'b0, 4'h0, 8'hFF);
    chk_rd(1'b0, 4'h0, 8'h00);
    wr(1'b0, OFS_MASK, 8'h5A);
    chk_rd(1'b0, OFS_MASK, 8'h5A);
    wr(1'b1, OFS_WAKE, 8'hFF);
    chk_rd(1'b1, OFS_WAKE, 8'h8F);
    chk({4'h0, wake_en_o}, 8'h00);
    chk({7'h00, sink_w}, 8'h01);
    wr(1'b1, OFS_WAKE, 8'h05);
    chk_rd(1'b1, OFS_WAKE, 8'h05);
    chk({4'h0, wake_en_o}, 8'h0A);
    chk({7'h00, sink_w}, 8'h00);
    wr(1'b1, OFS_TCTL, 8'h7F);
    chk_rd(1'b1, OFS_TCTL, 8'h3F);
    for (int k = 0; k < 4; k++)
    begin
      cpu(k);
      chk_rd(1'b1, OFS_TCTL, (k % 2) ? 8'h3F : 8'h7F);
    end
    wr(1'b1, OFS_WDOG, 8'hFF);
    chk_rd(1'b1, OFS_WDOG, 8'h0F);
    chk({7'h00, watchdog_en_o}, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wr(1'b1, OFS_CNTSRC + 4'(k), 8'hC3 ^ 8'(k));
      chk_rd(1'b1, OFS_CNTSRC + 4'(k), 8'hC3 ^ 8'(k));
    end
    $display("register test done");
    for (int k = 0; k < 8; k++)
    begin
      wr(1'b1, OFS_WDOG, 8'h08 | 8'(k));
      gap(5, (1 << k) * 6);
    end
    wr(1'b1, OFS_WDOG, 8'h00);
    cnt(5, 200, c);
    chk_n(c, 0);
    wr(1'b1, OFS_TCTL, 8'h00);
    gap(6, 2);
    for (int k = 0; k < 8; k++)
    begin
      wr(1'b1, OFS_TCTL, 8'h08 | 8'(k));
      gap(6, (2 << k) * 2);
    end
    wr(1'b1, OFS_TCTL, 8'h20);
    gap(6, 10);
    lag(l0);
    wr(1'b1, OFS_TCTL, 8'h30);
    gap(6, 10);
    lag(l1);
    chk_n(l1 - l0, 5);
    $display("prescaler test done");
    cpu(0);
    wr(1'b0, OFS_MASK, 8'hFF);
    wr(1'b0, OFS_C1PRE, 8'h03);
    wr(1'b0, OFS_C2PRE, 8'h01);
    wr(1'b1, OFS_CNTSRC, 8'h18);
    gap(1, 64);
    gap(2, 48);
    wr(1'b1, OFS_CNTSRC, 8'h81);
    gap(1, 96);
    gap(2, 32);
    wr(1'b0, OFS_HIPRE, 8'h01);
    wr(1'b0, OFS_LOPRE, 8'h02);
    wr(1'b1, OFS_PULSRC, 8'h88);
    gap(7, 80);
    gap(4, 80);
    gap(3, 80);
    wr(1'b0, OFS_LOPRE, 8'h04);
    gap(7, 112);
    wr(1'b1, OFS_PULSRC, 8'h10);
    gap(7, 144);
    wr(1'b0, OFS_MASK, 8'h00);
    cnt(4, 400, c);
    chk_n(c, 0);
    wr(1'b0, OFS_MASK, 8'hFF);
    cpu(1);
    cnt(4, 400, c);
    chk_n(c, 0);
    $display("counter test done");
    cpu(0);
    wr(1'b1, OFS_TCTL, 8'h00);
    ext(1'b1, 1);
    ext(1'b0, 0);
    wr(1'b1, OFS_TCTL, 8'h80);
    ext(1'b1, 0);
    ext(1'b0, 1);
    $display("external interrupt test done");
    finish_test();
  end
endmodule : tpc_bank_tb_top
